// File: bopc_pkg.sv
// Constants, field layouts and types shared by the binary output pulse control block.
package bopc_pkg;

  // ==========================================================================
  // Clock and timing
  // ==========================================================================
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned TICK_MS = 10;
  localparam int unsigned TICK_CYCLES = TICK_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned PULSE_MIN_MS = 50;
  localparam int unsigned PULSE_MAX_MS = 3600000;
  localparam int unsigned PULSE_DEF_MS = 200;

  // ==========================================================================
  // Field widths and ranges
  // ==========================================================================
  localparam int unsigned NUM_OUT = 2;
  localparam int unsigned IND_NUM = 16;
  localparam int unsigned IND_SEL_W = 5;
  localparam int unsigned CNT_NUM = 5;
  localparam int unsigned CNT_SEL_W = 3;
  localparam int unsigned PT_W = 19;
  localparam int unsigned STEP_W = 24;
  localparam int unsigned PEND_W = 8;
  localparam logic [PT_W-1:0] PT_MIN = PT_W'(PULSE_MIN_MS / TICK_MS);
  localparam logic [PT_W-1:0] PT_MAX = PT_W'(PULSE_MAX_MS / TICK_MS);
  localparam logic [PT_W-1:0] PT_DEF = PT_W'(PULSE_DEF_MS / TICK_MS);
  // Energy step is counted in tenths of Wh, VAh or varh.
  localparam logic [STEP_W-1:0] STEP_MIN = 24'h000001;
  localparam logic [STEP_W-1:0] STEP_MAX = 24'h989680;
  localparam logic [STEP_W-1:0] STEP_DEF = 24'h00000A;

  // ==========================================================================
  // Source selections
  // ==========================================================================
  localparam logic SRC_IND = 1'b0;
  localparam logic SRC_CNT = 1'b1;
  localparam logic [IND_SEL_W-1:0] IND_NONE = 5'h00;
  localparam logic [CNT_SEL_W-1:0] CNT_NONE = 3'h0;
  localparam logic [CNT_SEL_W-1:0] CNT_ACT_SUPPLY = 3'h1;
  localparam logic [CNT_SEL_W-1:0] CNT_ACT_DEMAND = 3'h2;
  localparam logic [CNT_SEL_W-1:0] CNT_REACT_IND = 3'h3;
  localparam logic [CNT_SEL_W-1:0] CNT_REACT_CAP = 3'h4;
  localparam logic [CNT_SEL_W-1:0] CNT_APPARENT = 3'h5;

  typedef enum logic [1:0] {
    MODE_PERSIST,
    MODE_FAILSAFE,
    MODE_PULSE,
    MODE_PULSE_RETRIG
  } bopc_mode_e;

  typedef struct packed {
    logic src_type;
    logic [IND_SEL_W-1:0] ind_sel;
    logic [CNT_SEL_W-1:0] cnt_sel;
    logic invert;
    bopc_mode_e mode;
    logic [STEP_W-1:0] step;
    logic [PT_W-1:0] ptime;
  } bopc_cfg_s;

  localparam bopc_cfg_s CFG_RESET = '{
    src_type: SRC_IND,
    ind_sel: IND_NONE,
    cnt_sel: CNT_NONE,
    invert: 1'b0,
    mode: MODE_PERSIST,
    step: STEP_DEF,
    ptime: PT_DEF
  };

endpackage

// File: bopc_relay_model.sv
// Relay-side pulse counter model watching one binary output.
`timescale 1ns/10ps
module bopc_relay_model (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic line,
  output logic [15:0] pulse_cnt,
  output logic [15:0] width
);
  logic [15:0] run_ff;
  // ==========================================================================
  // Edge counting
  // ==========================================================================
  // A counting input sees rising edges only, so a missing low gap merges pulses.
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      pulse_cnt <= 16'h0000;
      width <= 16'h0000;
      run_ff <= 16'h0000;
    end
    else if (line)
    begin
      if (run_ff == 16'h0000)
      begin
        pulse_cnt <= pulse_cnt + 16'h0001;
      end
      run_ff <= run_ff + 16'h0001;
    end
    else
    begin
      if (run_ff != 16'h0000)
      begin
        width <= run_ff;
      end
      run_ff <= 16'h0000;
    end
  end
endmodule

// File: bopc_timer.sv
// Pulse timer of one binary output, counting shared 10 ms ticks.
`timescale 1ns/10ps
module bopc_timer (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic tick,
  input wire logic start,
  input wire logic kill,
  input wire logic [bopc_pkg::PT_W-1:0] pulse_ticks,
  output logic busy
);

  typedef struct packed {
    logic [bopc_pkg::PT_W-1:0] cnt;
    logic busy;
  } bopc_tmr_s;

  bopc_tmr_s st_ff;
  bopc_tmr_s nxt_st;

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb
  begin
    nxt_st = st_ff;
    if (kill)
    begin
      nxt_st.cnt = '0;
      nxt_st.busy = 1'b0;
    end
    else if (start)
    begin
      // A start while busy reloads the count, which lengthens the pulse.
      nxt_st.cnt = pulse_ticks; // [R8]
      nxt_st.busy = 1'b1;
    end
    else if (st_ff.busy && tick)
    begin
      if (st_ff.cnt <= bopc_pkg::PT_W'(1))
      begin
        nxt_st.cnt = '0;
        nxt_st.busy = 1'b0;
      end
      else
      begin
        nxt_st.cnt = st_ff.cnt - 1'b1; // [R17]
      end
    end
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign busy = st_ff.busy;

endmodule

// File: bopc_top.sv
// Two binary outputs driven by indications or energy counters, with passive and active settings.
`timescale 1ns/10ps
// How it works
// [R1] Source type picks indication or counter, never both.
// [R2] Source none holds output off and idle.
// [R3] Inversion complements indication when set.
// [R4] Persistent follows indication, holds when invalid.
// [R5] Fail-safe invalid forces output to inversion level.
// [R6] Plain pulse ignores changes while pulse on.
// [R7] Retrigger pulse restarts timer on change.
// [R8] Pulse ON time is count times 10 ms.
// [R9] Pulse time 50 ms to 3600000 ms, default 200.
// [R10] Pulse time serves pulse modes and counters.
// [R11] Activation sets persistent output from indication; if old active setting was pulse, counter or none it is forced off instead.
// [R12] Activation switches running pulse off at once.
// [R13] Counter emits one pulse per energy step.
// [R14] Counter selectable among five energy quantities.
// [R15] Written settings stay passive until activation.
// [R16] Both outputs identical with own settings, timers.
// [R17] Pulse timers count a common 10 ms tick.
// [R18] Energy accumulates, subtracts step, queues due pulses.
module bopc_top #(
  parameter int unsigned TICK_CYCLES = bopc_pkg::TICK_CYCLES
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [bopc_pkg::IND_NUM-1:0] ind_value,
  input wire logic [bopc_pkg::IND_NUM-1:0] ind_valid,
  input wire logic [bopc_pkg::CNT_NUM-1:0] energy_strobe,
  input wire logic cfg_wr,
  input wire logic cfg_sel,
  input wire logic cfg_src_type,
  input wire logic [bopc_pkg::IND_SEL_W-1:0] cfg_ind_sel,
  input wire logic [bopc_pkg::CNT_SEL_W-1:0] cfg_cnt_sel,
  input wire logic cfg_invert,
  input wire logic [1:0] cfg_mode,
  input wire logic [bopc_pkg::STEP_W-1:0] cfg_step,
  input wire logic [bopc_pkg::PT_W-1:0] cfg_ptime,
  input wire logic cfg_activate,
  output logic [bopc_pkg::NUM_OUT-1:0] bin_out,
  output logic cfg_err,
  output logic [bopc_pkg::NUM_OUT-1:0] pulse_queued
);

  localparam int unsigned TCW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
  localparam logic [TCW-1:0] TICK_LAST = TCW'(TICK_CYCLES - 1);

  typedef struct packed {
    bopc_pkg::bopc_cfg_s [bopc_pkg::NUM_OUT-1:0] pas;
    bopc_pkg::bopc_cfg_s [bopc_pkg::NUM_OUT-1:0] act;
    logic [bopc_pkg::NUM_OUT-1:0] out;
    logic [bopc_pkg::NUM_OUT-1:0] prev;
    logic [bopc_pkg::NUM_OUT-1:0][bopc_pkg::STEP_W-1:0] acc;
    logic [bopc_pkg::NUM_OUT-1:0][bopc_pkg::PEND_W-1:0] pend;
    logic [bopc_pkg::NUM_OUT-1:0] queued;
    logic [TCW-1:0] tick_cnt;
    logic tick;
    logic err;
  } bopc_state_s;

  bopc_state_s st_ff;
  bopc_state_s nxt_st;
  bopc_pkg::bopc_cfg_s wr_cfg;
  logic [bopc_pkg::NUM_OUT-1:0] start;
  logic [bopc_pkg::NUM_OUT-1:0] kill;
  logic [bopc_pkg::NUM_OUT-1:0] busy;

  // ==========================================================================
  // Helpers
  // ==========================================================================
  // The selected source is none when the chosen origin names nothing.
  function automatic logic src_none(input bopc_pkg::bopc_cfg_s c);
    if (c.src_type == bopc_pkg::SRC_CNT)
    begin
      src_none = (c.cnt_sel == bopc_pkg::CNT_NONE); // [R1]
    end
    else
    begin
      src_none = (c.ind_sel == bopc_pkg::IND_NONE); // [R1]
    end
  endfunction

  // Returns {valid, effective level} of the selected indication.
  function automatic logic [1:0] ind_eff(input bopc_pkg::bopc_cfg_s c,
                                         input logic [bopc_pkg::IND_NUM-1:0] val,
                                         input logic [bopc_pkg::IND_NUM-1:0] vld);
    logic [$clog2(bopc_pkg::IND_NUM)-1:0] idx;
    // Wrapping the index keeps a none selection from reading past the vector.
    idx = c.ind_sel[$clog2(bopc_pkg::IND_NUM)-1:0] - 1'b1;
    ind_eff = {vld[idx], val[idx] ^ c.invert}; // [R3]
  endfunction

  function automatic logic is_pulse(input bopc_pkg::bopc_cfg_s c);
    is_pulse = (c.src_type == bopc_pkg::SRC_CNT) || (c.mode == bopc_pkg::MODE_PULSE) ||
               (c.mode == bopc_pkg::MODE_PULSE_RETRIG);
  endfunction

  function automatic logic cfg_ok(input bopc_pkg::bopc_cfg_s c);
    cfg_ok = (c.ptime >= bopc_pkg::PT_MIN) && (c.ptime <= bopc_pkg::PT_MAX) && // [R9]
             (c.step >= bopc_pkg::STEP_MIN) && (c.step <= bopc_pkg::STEP_MAX) && // [R13]
             (c.cnt_sel <= bopc_pkg::CNT_APPARENT) && // [R14]
             (c.ind_sel <= bopc_pkg::IND_SEL_W'(bopc_pkg::IND_NUM));
  endfunction

  always_comb
  begin
    wr_cfg.src_type = cfg_src_type;
    wr_cfg.ind_sel = cfg_ind_sel;
    wr_cfg.cnt_sel = cfg_cnt_sel;
    wr_cfg.invert = cfg_invert;
    wr_cfg.mode = bopc_pkg::bopc_mode_e'(cfg_mode);
    wr_cfg.step = cfg_step;
    wr_cfg.ptime = cfg_ptime;
  end

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb
  begin
    logic [1:0] ie;
    logic [1:0] ie_new;
    logic [bopc_pkg::STEP_W:0] sum;
    logic [bopc_pkg::PEND_W:0] pnd;
    logic due;
    bopc_pkg::bopc_cfg_s c;
    bopc_pkg::bopc_cfg_s cn;
    ie = '0;
    ie_new = '0;
    sum = '0;
    pnd = '0;
    due = 1'b0;
    c = st_ff.act[0];
    cn = st_ff.pas[0];
    nxt_st = st_ff;
    start = '0;
    kill = '0;

    // A single tick shared by both outputs keeps every pulse end other than a kill on the 10 ms grid.
    if (st_ff.tick_cnt >= TICK_LAST)
    begin
      nxt_st.tick_cnt = '0;
      nxt_st.tick = 1'b1; // [R17]
    end
    else
    begin
      nxt_st.tick_cnt = st_ff.tick_cnt + 1'b1;
      nxt_st.tick = 1'b0;
    end

    if (cfg_wr)
    begin
      if (cfg_ok(wr_cfg))
      begin
        nxt_st.pas[cfg_sel] = wr_cfg; // [R15]
        nxt_st.err = 1'b0;
      end
      else
      begin
        nxt_st.err = 1'b1;
      end
    end

    for (int i = 0; i < bopc_pkg::NUM_OUT; i++) // [R16]
    begin
      c = st_ff.act[i];
      cn = st_ff.pas[i];
      ie = ind_eff(c, ind_value, ind_valid);
      ie_new = ind_eff(cn, ind_value, ind_valid);
      if (cfg_activate)
      begin
        nxt_st.act[i] = cn; // [R15]
        nxt_st.acc[i] = '0;
        nxt_st.pend[i] = '0;
        nxt_st.queued[i] = 1'b0;
        kill[i] = 1'b1; // [R12]
        nxt_st.prev[i] = ie_new[0];
        if (src_none(cn) || is_pulse(cn) || is_pulse(c) || src_none(c))
        begin
          nxt_st.out[i] = 1'b0; // [R12]
        end
        else if (ie_new[1])
        begin
          nxt_st.out[i] = ie_new[0]; // [R11]
        end
        else if (cn.mode == bopc_pkg::MODE_FAILSAFE)
        begin
          nxt_st.out[i] = cn.invert; // [R5]
        end
      end
      else if (src_none(c))
      begin
        kill[i] = 1'b1; // [R2]
        nxt_st.out[i] = 1'b0; // [R2]
        nxt_st.acc[i] = '0;
        nxt_st.pend[i] = '0;
        nxt_st.queued[i] = 1'b0;
      end
      else if (c.src_type == bopc_pkg::SRC_CNT)
      begin
        sum = {1'b0, st_ff.acc[i]} +
              {{bopc_pkg::STEP_W{1'b0}}, energy_strobe[c.cnt_sel - 1'b1]}; // [R14]
        due = (sum >= {1'b0, c.step});
        if (due)
        begin
          sum = sum - {1'b0, c.step}; // [R18]
        end
        nxt_st.acc[i] = sum[bopc_pkg::STEP_W-1:0];
        pnd = {1'b0, st_ff.pend[i]} + {{bopc_pkg::PEND_W{1'b0}}, due};
        if (pnd[bopc_pkg::PEND_W])
        begin
          pnd = {1'b0, {bopc_pkg::PEND_W{1'b1}}};
        end
        // Waiting for both busy and out low leaves an OFF gap between queued pulses.
        if ((pnd != '0) && !busy[i] && !st_ff.out[i])
        begin
          start[i] = 1'b1; // [R13]
          pnd = pnd - 1'b1;
        end
        nxt_st.pend[i] = pnd[bopc_pkg::PEND_W-1:0]; // [R18]
        nxt_st.queued[i] = (pnd != '0);
        nxt_st.out[i] = busy[i]; // [R10]
      end
      else
      begin
        unique case (c.mode)
          bopc_pkg::MODE_PERSIST:
          begin
            if (ie[1])
            begin
              nxt_st.out[i] = ie[0]; // [R4]
            end
          end
          bopc_pkg::MODE_FAILSAFE:
          begin
            nxt_st.out[i] = ie[1] ? ie[0] : c.invert; // [R5]
          end
          bopc_pkg::MODE_PULSE, bopc_pkg::MODE_PULSE_RETRIG:
          begin
            if (ie[1] && (ie[0] != st_ff.prev[i]))
            begin
              nxt_st.prev[i] = ie[0];
              if (!busy[i])
              begin
                start[i] = 1'b1; // [R6]
              end
              else if (c.mode == bopc_pkg::MODE_PULSE_RETRIG)
              begin
                start[i] = 1'b1; // [R7]
              end
            end
            nxt_st.out[i] = busy[i]; // [R10]
          end
        endcase
      end
    end
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      st_ff.pas <= {bopc_pkg::NUM_OUT{bopc_pkg::CFG_RESET}};
      st_ff.act <= {bopc_pkg::NUM_OUT{bopc_pkg::CFG_RESET}};
      st_ff.out <= '0;
      st_ff.prev <= '0;
      st_ff.acc <= '0;
      st_ff.pend <= '0;
      st_ff.queued <= '0;
      st_ff.tick_cnt <= '0;
      st_ff.tick <= 1'b0;
      st_ff.err <= 1'b0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================================
  // Pulse timers
  // ==========================================================================
  for (genvar g = 0; g < bopc_pkg::NUM_OUT; g++)
  begin : g_tmr
    bopc_timer u_timer (
      .core_clk(core_clk),
      .reset(reset),
      .tick(st_ff.tick),
      .start(start[g]),
      .kill(kill[g]),
      .pulse_ticks(st_ff.act[g].ptime),
      .busy(busy[g])
    );
  end

  assign bin_out = st_ff.out;
  assign cfg_err = st_ff.err;
  assign pulse_queued = st_ff.queued;

endmodule

// File: bopc_top_chk.sv
// Concurrent checks on the ports of the binary output pulse control block.
`timescale 1ns/10ps
module bopc_top_chk #(
  parameter int unsigned TICK_CYCLES = bopc_pkg::TICK_CYCLES
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [15:0] ind_value,
  input wire logic [15:0] ind_valid,
  input wire logic [4:0] energy_strobe,
  input wire logic cfg_wr,
  input wire logic cfg_sel,
  input wire logic cfg_src_type,
  input wire logic [4:0] cfg_ind_sel,
  input wire logic [2:0] cfg_cnt_sel,
  input wire logic cfg_invert,
  input wire logic [1:0] cfg_mode,
  input wire logic [23:0] cfg_step,
  input wire logic [18:0] cfg_ptime,
  input wire logic cfg_activate,
  input wire logic [1:0] bin_out,
  input wire logic cfg_err,
  input wire logic [1:0] pulse_queued
);
  // ==========================================================================
  // Shadow of output 0 settings
  // ==========================================================================
  // Only output 0 is shadowed; output 1 is the same logic and is left to the bench.
  logic [11:0] pas_ff;
  logic [11:0] act_ff;
  logic wr_ok;
  logic eff;
  logic vld;
  logic persist;
  assign wr_ok = (cfg_ptime >= bopc_pkg::PT_MIN) && (cfg_ptime <= bopc_pkg::PT_MAX)
    && (cfg_step >= bopc_pkg::STEP_MIN) && (cfg_step <= bopc_pkg::STEP_MAX)
    && (cfg_cnt_sel <= bopc_pkg::CNT_APPARENT) && (cfg_ind_sel <= 5'h10);
  assign eff = ind_value[4'(act_ff[9:6] - 4'h1)] ^ act_ff[2];
  assign vld = ind_valid[4'(act_ff[9:6] - 4'h1)];
  assign persist = !act_ff[11] && (act_ff[10:6] != 5'h00) && !act_ff[1] && !cfg_activate;
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      pas_ff <= 12'h000;
      act_ff <= 12'h000;
    end
    else
    begin
      if (cfg_wr && wr_ok && !cfg_sel)
      begin
        pas_ff <= {cfg_src_type, cfg_ind_sel, cfg_cnt_sel, cfg_invert, cfg_mode};
      end
      if (cfg_activate)
      begin
        act_ff <= pas_ff;
      end
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // ==========================================================================
  // Assertions
  // ==========================================================================
  a_err_hold: assert property (!cfg_wr |=> $stable(cfg_err))
    else $error("cfg_err moved without a write");
  a_err_bad: assert property (cfg_wr && !wr_ok |=> cfg_err)
    else $error("bad write not flagged");
  a_err_good: assert property (cfg_wr && wr_ok |=> !cfg_err)
    else $error("good write flagged");
  a_pulse_off: assert property (cfg_activate && (act_ff[11] || act_ff[1])
    && (pas_ff[11] || pas_ff[1]) |-> ##2 !bin_out[0]) else $error("pulse kept on activation");
  a_none_idle: assert property ((act_ff[11] ? act_ff[5:3] == 3'h0 : act_ff[10:6] == 5'h00)
    |=> !bin_out[0]) else $error("output active with no source");
  a_persist_follow: assert property (persist && vld && !$past(cfg_activate)
    |=> bin_out[0] == $past(eff)) else $error("output not following indication");
  a_persist_hold: assert property (persist && !act_ff[0] && !vld && !$past(cfg_activate)
    |=> $stable(bin_out[0])) else $error("output moved on invalid indication");
  a_fail_safe: assert property (persist && act_ff[0] && !vld && !$past(cfg_activate)
    |=> bin_out[0] == act_ff[2]) else $error("fail-safe level wrong");
  cp_act: cover property (cfg_activate);
  cp_pulse: cover property ($rose(bin_out[0]) && act_ff[1]);
  cp_queue: cover property (pulse_queued[1]);
endmodule
bind bopc_top bopc_top_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.core_clk(core_clk),
  .reset(reset), .ind_value(ind_value), .ind_valid(ind_valid), .energy_strobe(energy_strobe),
  .cfg_wr(cfg_wr), .cfg_sel(cfg_sel), .cfg_src_type(cfg_src_type), .cfg_ind_sel(cfg_ind_sel),
  .cfg_cnt_sel(cfg_cnt_sel), .cfg_invert(cfg_invert), .cfg_mode(cfg_mode),
  .cfg_step(cfg_step), .cfg_ptime(cfg_ptime), .cfg_activate(cfg_activate),
  .bin_out(bin_out), .cfg_err(cfg_err), .pulse_queued(pulse_queued));

// File: bopc_top_tb.sv
// Self-checking testbench for the binary output pulse control block.
`timescale 1ns/10ps
module bopc_top_tb;
  logic core_clk, reset, cfg_wr, cfg_sel, cfg_src_type, cfg_invert, cfg_activate, cfg_err;
  logic [15:0] ind_value, ind_valid, cnt0, cnt1, wid0, wid1, base;
  logic [4:0] energy_strobe, cfg_ind_sel;
  logic [2:0] cfg_cnt_sel;
  logic [1:0] cfg_mode, bin_out, pulse_queued;
  logic [23:0] cfg_step;
  logic [18:0] cfg_ptime;
  int n_fail, n_tests;
  // A tick of 4 cycles keeps pulses short; all widths below derive from it.
  bopc_top #(.TICK_CYCLES(4)) uut (.core_clk(core_clk), .reset(reset), .ind_value(ind_value),
    .ind_valid(ind_valid), .energy_strobe(energy_strobe), .cfg_wr(cfg_wr), .cfg_sel(cfg_sel),
    .cfg_src_type(cfg_src_type), .cfg_ind_sel(cfg_ind_sel), .cfg_cnt_sel(cfg_cnt_sel),
    .cfg_invert(cfg_invert), .cfg_mode(cfg_mode), .cfg_step(cfg_step), .cfg_ptime(cfg_ptime),
    .cfg_activate(cfg_activate), .bin_out(bin_out), .cfg_err(cfg_err),
    .pulse_queued(pulse_queued));
  bopc_relay_model rly0 (.core_clk(core_clk), .reset(reset), .line(bin_out[0]),
    .pulse_cnt(cnt0), .width(wid0));
  bopc_relay_model rly1 (.core_clk(core_clk), .reset(reset), .line(bin_out[1]),
    .pulse_cnt(cnt1), .width(wid1));
  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic test_done();
    if (n_fail == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic wr(input logic s, input logic src, input logic [4:0] ind,
    input logic [2:0] cnt, input logic inv, input logic [1:0] md, input logic [23:0] st,
    input logic [18:0] pt, input logic e);
    @(negedge core_clk);
    {cfg_sel, cfg_src_type, cfg_ind_sel, cfg_cnt_sel, cfg_invert, cfg_mode} =
      {s, src, ind, cnt, inv, md};
    cfg_step = st;
    cfg_ptime = pt;
    cfg_wr = 1'b1;
    @(negedge core_clk);
    cfg_wr = 1'b0;
    cyc(1);
    chk(cfg_err, e);
  endtask
  task automatic act();
    @(negedge core_clk);
    cfg_activate = 1'b1;
    @(negedge core_clk);
    cfg_activate = 1'b0;
  endtask
  task automatic wait_lvl(input logic lvl);
    int k;
    k = 0;
    while (bin_out[0] !== lvl && k < 100)
    begin
      @(negedge core_clk);
      k++;
    end
    if (k == 100)
    begin
      n_fail++;
      test_done();
    end
  endtask
  task automatic strobe(input int b);
    @(negedge core_clk);
    energy_strobe = 5'h01 << b;
    @(negedge core_clk);
    energy_strobe = 5'h00;
  endtask
  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial
  begin
    n_fail = 0;
    n_tests = 0;
    {reset, cfg_wr, cfg_sel, cfg_src_type, cfg_invert, cfg_activate} = 6'h20;
    {cfg_ind_sel, cfg_cnt_sel, cfg_mode, energy_strobe} = 15'h0000;
    {cfg_step, cfg_ptime} = {24'h00000A, 19'h00014};
    ind_valid = 16'hFFFF;
    ind_value = 16'h0001;
    cyc(20);
    reset = 1'b0;
    chk({cfg_err, pulse_queued, bin_out}, 32'h0);
    wr(0, 0, 5'h01, 3'h0, 0, 2'h0, 24'h00000A, 19'h00014, 0);
    chk(bin_out, 32'h0);
    act();
    cyc(1);
    chk(bin_out, 32'h1);
    ind_value[0] = 1'b0;
    cyc(2);
    chk(bin_out[0], 32'h0);
    {ind_valid[0], ind_value[0]} = 2'h1;
    cyc(2);
    chk(bin_out[0], 32'h0);
    wr(0, 0, 5'h02, 3'h0, 1, 2'h1, 24'h00000A, 19'h00014, 0);
    act();
    cyc(1);
    chk(bin_out, 32'h1);
    ind_value[1] = 1'b1;
    cyc(2);
    chk(bin_out, 32'h0);
    ind_valid[1] = 1'b0;
    cyc(2);
    chk(bin_out, 32'h1);
    ind_valid = 16'hFFFF;
    wr(1, 0, 5'h11, 3'h0, 0, 2'h0, 24'h00000A, 19'h00014, 1);
    wr(1, 1, 5'h00, 3'h6, 0, 2'h0, 24'h00000A, 19'h00014, 1);
    wr(1, 1, 5'h00, 3'h1, 0, 2'h0, 24'h000000, 19'h00014, 1);
    wr(1, 1, 5'h00, 3'h1, 0, 2'h0, 24'h989681, 19'h00014, 1);
    wr(1, 0, 5'h01, 3'h0, 0, 2'h2, 24'h00000A, 19'h00004, 1);
    wr(1, 0, 5'h01, 3'h0, 0, 2'h2, 24'h00000A, 19'h57E41, 1);
    wr(1, 0, 5'h00, 3'h0, 0, 2'h0, 24'h989680, 19'h57E40, 0);
    for (int md = 2; md < 4; md++)
    begin
      wr(0, 0, 5'h01, 3'h0, 0, md[1:0], 24'h00000A, 19'h00005, 0);
      act();
      cyc(2);
      base = cnt0;
      ind_value[0] = ~ind_value[0];
      wait_lvl(1);
      cyc(8);
      ind_value[0] = ~ind_value[0];
      wait_lvl(0);
      cyc(30);
      chk(cnt0 - base, 32'h1);
      chk((md == 2) ? (wid0 >= 16'd17 && wid0 <= 16'd21) : (wid0 > 16'd24), 32'h1);
    end
    ind_value[0] = ~ind_value[0];
    wait_lvl(1);
    cyc(3);
    act();
    cyc(1);
    chk(bin_out[0], 32'h0);
    wr(0, 0, 5'h00, 3'h0, 0, 2'h0, 24'h00000A, 19'h00014, 0);
    act();
    ind_value[0] = ~ind_value[0];
    cyc(4);
    chk(bin_out[0], 32'h0);
    for (int q = 1; q < 6; q++)
    begin
      wr(1, 1, 5'h00, q[2:0], 0, 2'h0, 24'h000002, 19'h00005, 0);
      act();
      base = cnt1;
      for (int b = 0; b < 5; b++)
        if (b != q - 1)
          strobe(b);
      repeat (4) strobe(q - 1);
      chk(pulse_queued[1], 32'h1);
      cyc(80);
      chk(cnt1 - base, 32'h2);
      chk(bin_out[0], 32'h0);
    end
    test_done();
  end
endmodule
